// *** core/qrsp_pkg.sv ***
// constants and types shared by the pin-clocking burst sram core
package qrsp_pkg;

  // =====================================================================
  // timing
  localparam int SYS_CLK_NS = 50;
  // both output clocks high this long means they are tied high
  localparam int OCLK_TIE_NS = 1000;
  localparam int OCLK_TIE_CYC = (OCLK_TIE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int TIE_CNT_W = 6;
  localparam logic [TIE_CNT_W-1:0] TIE_CNT_RST = 6'h00;

  // =====================================================================
  // burst shape
  localparam int BURST_LEN = 4;
  localparam int BEAT_W = 2;
  localparam logic [BEAT_W-1:0] BEAT_0 = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_1 = 2'h1;
  localparam logic [BEAT_W-1:0] BEAT_2 = 2'h2;
  localparam logic [BEAT_W-1:0] BEAT_3 = 2'h3;

  // =====================================================================
  // reset values
  localparam logic FLAG_RST = 1'b0;
  localparam logic STROBE_RST = 1'b0;

  typedef enum logic [0:0] {
    BURST_IDLE,
    BURST_RUN
  } qrsp_burst_e;

endpackage

// *** core/qrsp_sync.sv ***
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module qrsp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] pin_raw,
  output logic [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // first stage feeds only the second stage
  always_comb begin
    meta_d = pin_raw;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (clk_en) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign pin_sync = sync_q;

endmodule

// *** core/qrsp_core.sv ***
// separate-port four-word burst sram core sampled on a fast system clock
`timescale 1ns/1ps
module qrsp_core #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 18,
  parameter int LANES = 2,
  parameter int NC_N = 4
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic in_clk_true,
  input wire logic in_clk_comp,
  input wire logic out_clk_true,
  input wire logic out_clk_comp,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic [DATA_W-1:0] wr_data,
  // nibble_lane_write_select_n on the eight-bit build (DATA_W 8, LANES 2)
  input wire logic [LANES-1:0] byte_lane_write_select_n,
  input wire logic dll_disable_n,
  input wire logic [NC_N-1:0] nc_ball,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_data_oe,
  output logic echo_strobe_true,
  output logic echo_strobe_comp,
  output logic dll_bypassed,
  output logic [NC_N-1:0] nc_scan_level
);

  localparam int LANE_W = DATA_W / LANES;
  localparam int BEAT_W = qrsp_pkg::BEAT_W;
  localparam int IDX_W = ADDR_W + BEAT_W;
  localparam int DEPTH = (2 ** ADDR_W) * qrsp_pkg::BURST_LEN;
  localparam int SYNC_W = 4 + ADDR_W + 2 + DATA_W + LANES + 1 + NC_N;

  // =====================================================================
  // helpers
  function automatic logic [IDX_W-1:0] word_index(input logic [ADDR_W-1:0] a, input logic [BEAT_W-1:0] b);
    return {a, b};
  endfunction

  function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] old_w,
                                                     input logic [DATA_W-1:0] new_w,
                                                     input logic [LANES-1:0] sel_n);
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (!sel_n[i]) begin
        res[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
      end
    end
    return res;
  endfunction

  // =====================================================================
  // pin synchronisers
  // every pin goes through the same two flops, so data keeps its place against the clock edges
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] pin_s;
  logic k_s;
  logic kc_s;
  logic c_s;
  logic cc_s;
  logic [ADDR_W-1:0] addr_s;
  logic read_n_s;
  logic write_n_s;
  logic [DATA_W-1:0] wdata_s;
  logic [LANES-1:0] wsel_n_s;
  logic dll_n_s;
  logic [NC_N-1:0] nc_s;

  assign pin_raw = {in_clk_true, in_clk_comp, out_clk_true, out_clk_comp, addr, read_n, write_n,
                    wr_data, byte_lane_write_select_n, dll_disable_n, nc_ball};

  qrsp_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .pin_raw(pin_raw),
    .pin_sync(pin_s)
  );

  assign {k_s, kc_s, c_s, cc_s, addr_s, read_n_s, write_n_s, wdata_s, wsel_n_s, dll_n_s, nc_s} = pin_s;

  // =====================================================================
  // clock edges and output reference selection
  logic k_prev_q, k_prev_d;
  logic kc_prev_q, kc_prev_d;
  logic c_prev_q, c_prev_d;
  logic cc_prev_q, cc_prev_d;
  logic [qrsp_pkg::TIE_CNT_W-1:0] tie_cnt_q, tie_cnt_d;
  logic use_in_clk_q, use_in_clk_d;
  logic k_rise;
  logic kc_rise;
  logic ref_true_rise;
  logic ref_comp_rise;
  logic ref_true_lvl;
  logic ref_comp_lvl;

  assign k_rise = k_s & ~k_prev_q;
  assign kc_rise = kc_s & ~kc_prev_q;

  always_comb begin
    k_prev_d = k_s;
    kc_prev_d = kc_s;
    c_prev_d = c_s;
    cc_prev_d = cc_s;
    tie_cnt_d = tie_cnt_q;
    use_in_clk_d = use_in_clk_q;
    // a single low sample of either output clock means they are really running
    if (c_s && cc_s) begin
      if (tie_cnt_q < qrsp_pkg::TIE_CNT_W'(qrsp_pkg::OCLK_TIE_CYC)) begin
        tie_cnt_d = tie_cnt_q + qrsp_pkg::TIE_CNT_W'(1);
      end else begin
        use_in_clk_d = 1'b1;
      end
    end else begin
      tie_cnt_d = qrsp_pkg::TIE_CNT_RST;
      use_in_clk_d = 1'b0;
    end
  end

  // tied-high output clocks are assumed never to toggle, so no glitch guard on the switch back
  assign ref_true_rise = use_in_clk_q ? k_rise : (c_s & ~c_prev_q);
  assign ref_comp_rise = use_in_clk_q ? kc_rise : (cc_s & ~cc_prev_q);
  assign ref_true_lvl = use_in_clk_q ? k_s : c_s;
  assign ref_comp_lvl = use_in_clk_q ? kc_s : cc_s;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      k_prev_q <= qrsp_pkg::FLAG_RST;
      kc_prev_q <= qrsp_pkg::FLAG_RST;
      c_prev_q <= qrsp_pkg::FLAG_RST;
      cc_prev_q <= qrsp_pkg::FLAG_RST;
      tie_cnt_q <= qrsp_pkg::TIE_CNT_RST;
      use_in_clk_q <= qrsp_pkg::FLAG_RST;
    end else if (clk_en) begin
      k_prev_q <= k_prev_d;
      kc_prev_q <= kc_prev_d;
      c_prev_q <= c_prev_d;
      cc_prev_q <= cc_prev_d;
      tie_cnt_q <= tie_cnt_d;
      use_in_clk_q <= use_in_clk_d;
    end
  end

  // =====================================================================
  // request capture on the true input clock
  logic rd_last_q, rd_last_d;
  logic wr_last_q, wr_last_d;
  logic rd_arm_q, rd_arm_d;
  logic [ADDR_W-1:0] rd_arm_addr_q, rd_arm_addr_d;
  logic rd_next_q, rd_next_d;
  logic [ADDR_W-1:0] rd_next_addr_q, rd_next_addr_d;
  logic wr_arm_q, wr_arm_d;
  logic [ADDR_W-1:0] wr_arm_addr_q, wr_arm_addr_d;
  logic rd_take;
  logic wr_start;
  logic rd_accept;
  logic wr_accept;

  // a request right after an accepted one of the same kind is dropped
  assign rd_accept = k_rise & ~read_n_s & ~rd_last_q;
  assign wr_accept = k_rise & ~write_n_s & ~wr_last_q;
  assign wr_start = k_rise & wr_arm_q;

  always_comb begin
    rd_last_d = rd_last_q;
    wr_last_d = wr_last_q;
    rd_arm_d = rd_arm_q;
    rd_arm_addr_d = rd_arm_addr_q;
    rd_next_d = rd_next_q;
    rd_next_addr_d = rd_next_addr_q;
    wr_arm_d = wr_arm_q;
    wr_arm_addr_d = wr_arm_addr_q;
    if (rd_take) begin
      rd_next_d = 1'b0;
    end
    if (k_rise) begin
      rd_last_d = rd_accept;
      wr_last_d = wr_accept;
      // address taken at edge t moves on at edge t+1, ahead of the first output word
      if (rd_arm_q) begin
        rd_next_d = 1'b1;
        rd_next_addr_d = rd_arm_addr_q;
      end
      rd_arm_d = rd_accept;
      wr_arm_d = wr_accept;
      if (rd_accept) begin
        rd_arm_addr_d = addr_s;
      end
      if (wr_accept) begin
        wr_arm_addr_d = addr_s;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_last_q <= qrsp_pkg::FLAG_RST;
      wr_last_q <= qrsp_pkg::FLAG_RST;
      rd_arm_q <= qrsp_pkg::FLAG_RST;
      rd_arm_addr_q <= '0;
      rd_next_q <= qrsp_pkg::FLAG_RST;
      rd_next_addr_q <= '0;
      wr_arm_q <= qrsp_pkg::FLAG_RST;
      wr_arm_addr_q <= '0;
    end else if (clk_en) begin
      rd_last_q <= rd_last_d;
      wr_last_q <= wr_last_d;
      rd_arm_q <= rd_arm_d;
      rd_arm_addr_q <= rd_arm_addr_d;
      rd_next_q <= rd_next_d;
      rd_next_addr_q <= rd_next_addr_d;
      wr_arm_q <= wr_arm_d;
      wr_arm_addr_q <= wr_arm_addr_d;
    end
  end

  // =====================================================================
  // write burst and storage
  qrsp_pkg::qrsp_burst_e wr_state_q, wr_state_d;
  logic [BEAT_W-1:0] wr_beat_q, wr_beat_d;
  logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [DATA_W-1:0] mem_d [DEPTH];
  logic wr_store;
  logic [IDX_W-1:0] wr_idx;

  always_comb begin
    wr_state_d = wr_state_q;
    wr_beat_d = wr_beat_q;
    wr_addr_d = wr_addr_q;
    wr_store = 1'b0;
    wr_idx = word_index(wr_addr_q, wr_beat_q);
    unique case (wr_state_q)
      qrsp_pkg::BURST_IDLE: begin
        if (wr_start) begin
          wr_store = 1'b1;
          wr_idx = word_index(wr_arm_addr_q, qrsp_pkg::BEAT_0);
          wr_addr_d = wr_arm_addr_q;
          wr_beat_d = qrsp_pkg::BEAT_1;
          wr_state_d = qrsp_pkg::BURST_RUN;
        end
      end
      qrsp_pkg::BURST_RUN: begin
        // even words on the true edge, odd words on the complementary edge
        if ((k_rise && wr_beat_q == qrsp_pkg::BEAT_2) || (kc_rise && wr_beat_q[0])) begin
          wr_store = 1'b1;
          wr_beat_d = wr_beat_q + BEAT_W'(1);
          if (wr_beat_q == qrsp_pkg::BEAT_3) begin
            wr_state_d = qrsp_pkg::BURST_IDLE;
          end
        end
      end
    endcase
  end

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (wr_store) begin
      mem_d[wr_idx] = merge_lanes(mem_q[wr_idx], wdata_s, wsel_n_s);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_state_q <= qrsp_pkg::BURST_IDLE;
      wr_beat_q <= qrsp_pkg::BEAT_0;
      wr_addr_q <= '0;
    end else if (clk_en) begin
      wr_state_q <= wr_state_d;
      wr_beat_q <= wr_beat_d;
      wr_addr_q <= wr_addr_d;
    end
  end

  // storage keeps its content through reset, as a real array would
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  // =====================================================================
  // read burst launch and echo strobes
  qrsp_pkg::qrsp_burst_e rd_state_q, rd_state_d;
  logic [BEAT_W-1:0] rd_beat_q, rd_beat_d;
  logic [ADDR_W-1:0] rd_addr_q, rd_addr_d;
  logic [DATA_W-1:0] rd_data_q, rd_data_d;
  logic rd_oe_q, rd_oe_d;
  logic echo_true_q, echo_true_d;
  logic echo_comp_q, echo_comp_d;
  logic dll_byp_q, dll_byp_d;
  logic [NC_N-1:0] nc_q, nc_d;

  always_comb begin
    rd_state_d = rd_state_q;
    rd_beat_d = rd_beat_q;
    rd_addr_d = rd_addr_q;
    rd_data_d = rd_data_q;
    rd_oe_d = rd_oe_q;
    rd_take = 1'b0;
    if (ref_comp_rise) begin
      if (rd_state_q == qrsp_pkg::BURST_RUN && rd_beat_q == qrsp_pkg::BEAT_2) begin
        rd_data_d = mem_q[word_index(rd_addr_q, rd_beat_q)];
        rd_beat_d = qrsp_pkg::BEAT_3;
      end else if (rd_next_q) begin
        // back-to-back bursts run seamless: word one follows the previous word four
        rd_take = 1'b1;
        rd_addr_d = rd_next_addr_q;
        rd_data_d = mem_q[word_index(rd_next_addr_q, qrsp_pkg::BEAT_0)];
        rd_oe_d = 1'b1;
        rd_beat_d = qrsp_pkg::BEAT_1;
        rd_state_d = qrsp_pkg::BURST_RUN;
      end else begin
        rd_oe_d = 1'b0;
        rd_data_d = '0;
        rd_state_d = qrsp_pkg::BURST_IDLE;
      end
    end else if (ref_true_rise && rd_state_q == qrsp_pkg::BURST_RUN && rd_beat_q[0]) begin
      rd_data_d = mem_q[word_index(rd_addr_q, rd_beat_q)];
      rd_beat_d = rd_beat_q + BEAT_W'(1);
      if (rd_beat_q == qrsp_pkg::BEAT_3) begin
        rd_state_d = qrsp_pkg::BURST_IDLE;
      end
    end
    // strobes follow the reference clocks in the same cycle as the data, and never stop
    echo_true_d = ref_true_lvl;
    echo_comp_d = ref_comp_lvl;
    // sampled timing needs no loop alignment; the bypass is reported for the pads
    dll_byp_d = ~dll_n_s;
    nc_d = nc_s;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_state_q <= qrsp_pkg::BURST_IDLE;
      rd_beat_q <= qrsp_pkg::BEAT_0;
      rd_addr_q <= '0;
      rd_data_q <= '0;
      rd_oe_q <= qrsp_pkg::FLAG_RST;
      echo_true_q <= qrsp_pkg::STROBE_RST;
      echo_comp_q <= qrsp_pkg::STROBE_RST;
      dll_byp_q <= qrsp_pkg::FLAG_RST;
      nc_q <= '0;
    end else if (clk_en) begin
      rd_state_q <= rd_state_d;
      rd_beat_q <= rd_beat_d;
      rd_addr_q <= rd_addr_d;
      rd_data_q <= rd_data_d;
      rd_oe_q <= rd_oe_d;
      echo_true_q <= echo_true_d;
      echo_comp_q <= echo_comp_d;
      dll_byp_q <= dll_byp_d;
      nc_q <= nc_d;
    end
  end

  assign rd_data = rd_data_q;
  assign rd_data_oe = rd_oe_q;
  assign echo_strobe_true = echo_true_q;
  assign echo_strobe_comp = echo_comp_q;
  assign dll_bypassed = dll_byp_q;
  assign nc_scan_level = nc_q;

endmodule

// *** verif/qrsp_core_chk.sv ***
// concurrent checks on the pins of the burst sram core
`timescale 1ns/1ps
module qrsp_core_chk #(
  parameter int DATA_W = 18,
  parameter int NC_N = 4
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic in_clk_true,
  input wire logic in_clk_comp,
  input wire logic out_clk_true,
  input wire logic out_clk_comp,
  input wire logic dll_disable_n,
  input wire logic [NC_N-1:0] nc_ball,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic rd_data_oe,
  input wire logic echo_strobe_true,
  input wire logic echo_strobe_comp,
  input wire logic dll_bypassed,
  input wire logic [NC_N-1:0] nc_scan_level
);
  // ==========
  // helpers
  // quiet after reset or freeze: pin edges are seen late then
  logic [3:0] quiet_q, quiet_d;
  logic [5:0] tie_q, tie_d;
  always_comb begin
    quiet_d = (reset || !clk_en) ? 4'hf : quiet_q - 4'(quiet_q != 4'h0);
    tie_d = (reset || !(out_clk_true && out_clk_comp)) ? 6'h00 : tie_q + 6'(tie_q != 6'h3f);
  end
  always_ff @(posedge sys_clk) begin
    quiet_q <= quiet_d;
    tie_q <= tie_d;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset || quiet_q != 4'h0);

  // ==========
  // properties
  sequence s_burst_on;
    $rose(rd_data_oe);
  endsequence
  sequence s_true_rise;
    ##[2:5] $rose(echo_strobe_true);
  endsequence
  sequence s_ref(o, i, x);
    $past(o, 3) && ($past(i, 3) || !$past(x, 3));
  endsequence
  property p_dll;
    $stable(dll_disable_n) [*4] |=> dll_bypassed != $past(dll_disable_n);
  endproperty
  property p_nc;
    $stable(nc_ball) [*4] |=> nc_scan_level == $past(nc_ball);
  endproperty
  property p_echo_c;
    $rose(out_clk_true) |-> s_true_rise;
  endproperty
  property p_echo_idle;
    !rd_data_oe && $rose(out_clk_comp) |-> ##[2:5] $rose(echo_strobe_comp);
  endproperty
  property p_echo_k;
    tie_q > 6'h1e && $rose(in_clk_true) |-> s_true_rise;
  endproperty
  property p_first;
    s_burst_on |-> s_ref(out_clk_comp, in_clk_comp, out_clk_true);
  endproperty
  property p_second;
    s_burst_on |=> $stable(rd_data) [*3] ##1 s_ref(out_clk_true, in_clk_true, out_clk_comp);
  endproperty
  property p_len;
    s_burst_on |-> rd_data_oe [*8] ##1 rd_data_oe [*7];
  endproperty
  a_dll: assert property (p_dll) else $error("bypass flag wrong");
  a_nc: assert property (p_nc) else $error("scan level wrong");
  a_echo_c: assert property (p_echo_c) else $error("echo misses out clock");
  a_echo_idle: assert property (p_echo_idle) else $error("echo stopped");
  a_echo_k: assert property (p_echo_k) else $error("echo misses in clock");
  a_first: assert property (p_first) else $error("first word on wrong edge");
  a_second: assert property (p_second) else $error("second word on wrong edge");
  a_len: assert property (p_len) else $error("burst too short");
endmodule

bind qrsp_core qrsp_core_chk #(.DATA_W(DATA_W), .NC_N(NC_N)) qrsp_core_chk_inst (.sys_clk(sys_clk),
  .reset(reset), .clk_en(clk_en), .in_clk_true(in_clk_true), .in_clk_comp(in_clk_comp),
  .out_clk_true(out_clk_true), .out_clk_comp(out_clk_comp), .dll_disable_n(dll_disable_n),
  .nc_ball(nc_ball), .rd_data(rd_data), .rd_data_oe(rd_data_oe), .echo_strobe_true(echo_strobe_true),
  .echo_strobe_comp(echo_strobe_comp), .dll_bypassed(dll_bypassed), .nc_scan_level(nc_scan_level));

// *** verif/qrsp_ctrl_model.sv ***
// controller-side clock pairs for the burst sram core
`timescale 1ns/1ps
module qrsp_ctrl_model (
  input wire logic tie_out,
  output logic in_clk_true,
  output logic in_clk_comp,
  output logic out_clk_true,
  output logic out_clk_comp
);
  // known level from time zero, so the output clocks never start unknown
  logic c_ref = 1'b0;
  // ==========
  // clocks, 400 ns period, offset so edges never meet sys_clk edges
  initial begin
    in_clk_true = 1'b0;
    #7;
    forever begin
      #200;
      in_clk_true = ~in_clk_true;
    end
  end
  assign in_clk_comp = ~in_clk_true;
  always @(in_clk_true) c_ref <= #100 in_clk_true;
  // tie only while the core is idle: a mid-burst switch is undefined
  assign out_clk_true = tie_out | c_ref;
  assign out_clk_comp = tie_out | ~c_ref;
endmodule

// *** verif/quad_rate_sram_pin_clocking_tb_top.sv ***
// random self-checking bench for the burst sram core
`timescale 1ns/1ps
module quad_rate_sram_pin_clocking_tb_top;
  logic sys_clk, reset, clk_en, tie_out, read_n, write_n, dll_disable_n;
  logic in_clk_true, in_clk_comp, out_clk_true, out_clk_comp;
  logic rd_data_oe, echo_strobe_true, echo_strobe_comp, dll_bypassed;
  logic [3:0] addr, nc_ball, nc_scan_level, clks;
  logic [17:0] wr_data, rd_data;
  logic [1:0] sel_n;
  logic [17:0] mem [64];
  int mismatches = 0;
  int n_checks = 0;
  int k, seed;
  assign clks = {out_clk_comp, out_clk_true, in_clk_comp, in_clk_true};

  qrsp_ctrl_model qrsp_ctrl_model_inst (.tie_out(tie_out), .in_clk_true(in_clk_true),
    .in_clk_comp(in_clk_comp), .out_clk_true(out_clk_true), .out_clk_comp(out_clk_comp));
  qrsp_core qrsp_core_inst (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .in_clk_true(in_clk_true),
    .in_clk_comp(in_clk_comp), .out_clk_true(out_clk_true), .out_clk_comp(out_clk_comp), .addr(addr),
    .read_n(read_n), .write_n(write_n), .wr_data(wr_data), .byte_lane_write_select_n(sel_n),
    .dll_disable_n(dll_disable_n), .nc_ball(nc_ball), .rd_data(rd_data), .rd_data_oe(rd_data_oe),
    .echo_strobe_true(echo_strobe_true), .echo_strobe_comp(echo_strobe_comp), .dll_bypassed(dll_bypassed),
    .nc_scan_level(nc_scan_level));

  // ==========
  // tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check_word(input logic [17:0] got, input logic [17:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: read word got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_oe(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: read enable got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic check_pins(input logic [4:0] got, input logic [4:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: pins got %h exp %h", $time, got, exp);
    end
  endtask

  // word at slot i of one burst or two chained bursts, zero once they are over
  function automatic logic [17:0] exp_word(input logic [3:0] a, input logic [3:0] a2, input int i, input int n);
    if (i < 4) return mem[{a, 2'(i)}];
    if (i < n) return mem[{a2, 2'(i - 4)}];
    return 18'h0;
  endfunction

  function automatic logic [4:0] exp_pins(input logic dll_n, input logic [3:0] nc);
    return {~dll_n, nc};
  endfunction

  // returns just after the sys edge that first samples the pin rise
  task automatic wait_rise(input int s);
    logic p;
    p = clks[s];
    repeat (40) begin
      @(posedge sys_clk);
      #2;
      if (clks[s] && !p) return;
      p = clks[s];
    end
    mismatches++;
    $display("Error at %0t: no clock edge", $time);
    end_sim();
  endtask

  // inputs change one sys cycle after the edge, well away from the next one
  task automatic step(input int s);
    wait_rise(s);
    @(posedge sys_clk);
    #2;
  endtask

  task automatic wr_burst(input logic [3:0] a, input logic [1:0] keep, input logic hold);
    logic [17:0] w;
    logic [1:0] s;
    step(0);
    write_n = 1'b0;
    addr = a;
    step(0);
    write_n = hold;
    addr = 4'($urandom);
    for (int i = 0; i < 4; i++) begin
      w = 18'($urandom);
      s = 2'($urandom) & keep;
      wr_data = w;
      sel_n = s;
      if (!s[0]) mem[{a, 2'(i)}][8:0] = w[8:0];
      if (!s[1]) mem[{a, 2'(i)}][17:9] = w[17:9];
      step(i % 2);
      write_n = 1'b1;
    end
    sel_n = 2'h3;
    wr_data = ~wr_data;
  endtask

  task automatic rd_burst(input logic [3:0] a, input logic [3:0] a2, input logic hold, input logic b2b);
    int b;
    int n;
    b = tie_out ? 0 : 2;
    n = b2b ? 8 : 4;
    step(0);
    read_n = 1'b0;
    addr = a;
    step(0);
    read_n = hold;
    addr = 4'($urandom);
    wait_rise(0);
    // a second read two input clocks after the first must chain on with no gap
    read_n = ~b2b;
    addr = a2;
    for (int i = 0; i <= n; i++) begin
      wait_rise(b + 1 - i % 2);
      repeat (3) @(posedge sys_clk);
      #2;
      if (i == 1) read_n = 1'b1;
      check_word(rd_data, exp_word(a, a2, i, n));
      check_oe(rd_data_oe, i < n);
    end
  endtask

  // ==========
  // sequence
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    {reset, clk_en, tie_out, read_n, write_n, dll_disable_n} = 6'h37;
    {addr, nc_ball, wr_data, sel_n} = 28'h3;
    seed = $urandom(26500);
    repeat (4) @(posedge sys_clk);
    #2;
    reset = 1'b0;
    for (k = 0; k < 16; k++) wr_burst(4'(k), 2'h0, 1'b0);
    for (k = 0; k < 40; k++) begin
      if (k == 20) begin
        tie_out = 1'b1;
        repeat (40) @(posedge sys_clk);
        #2;
      end
      dll_disable_n = 1'($urandom);
      nc_ball = 4'($urandom);
      if (k == 7) begin
        clk_en = 1'b0;
        repeat (3) @(posedge sys_clk);
        #2;
        clk_en = 1'b1;
      end
      wr_burst(4'($urandom), 2'h3, k % 5 == 2);
      rd_burst(4'($urandom), 4'($urandom), k % 7 == 3, k % 4 == 1);
      check_pins({dll_bypassed, nc_scan_level}, exp_pins(dll_disable_n, nc_ball));
    end
    end_sim();
  end
endmodule
